// [eag_core.sv]
// Static pitch and roll from a gravity sample, roll-over, gimbal lock,
// gravity error and angle quality indicator.
// Assumes one clock, synchronous samples and a ready/valid source.
//
// Operation
// - Pitch is atan2 of minus x over the y-z magnitude within 90 degrees, roll is atan2 of y over z within 180 degrees.
// - The roll output is the same value that the unit rotation roll would give.
// - No yaw angle is produced, since gravity alone carries no yaw.
// - Roll-over is flagged whenever the roll magnitude is above 90 degrees.
// - Gravity purely along positive z gives zero pitch and zero roll; along negative z roll is 180 degrees.
// - Roll is flagged undefined when y and z are both zero, its value then being arbitrary.
// - Unit rotation pitch is flagged undefined when x and z are both zero.
// - Gravity error is the absolute difference between one g and the vector magnitude.
// - An error above the configured maximum puts the quality indicator in its error state.
// - The maximum error is a threshold input set by the user above expected accelerations.
// - While fusion is active the threshold never invalidates results.
// - While fusion is suspended the threshold check validates the angles.
// - Frame selection inputs reorient the unit axes to move gimbal lock away.
`timescale 1ns/1ns

module eag_core
    import eag_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic signed [EAG_SAMPLE_W-1:0] in_gx,
    input wire logic signed [EAG_SAMPLE_W-1:0] in_gy,
    input wire logic signed [EAG_SAMPLE_W-1:0] in_gz,
    input wire logic [1:0] frame_axis_sel,
    input wire logic [2:0] frame_negate,
    input wire logic fusion_active,
    input wire logic [EAG_SAMPLE_W-1:0] grav_err_max,
    output logic out_valid,
    output logic signed [EAG_ANG_W-1:0] pitch_out,
    output logic signed [EAG_ANG_W-1:0] roll_out,
    output logic rollover_out,
    output logic roll_lock_out,
    output logic unit_pitch_lock_out,
    output logic [EAG_SAMPLE_W-1:0] grav_err_out,
    output logic [1:0] angle_quality_indicator
);

    typedef logic signed [EAG_DP_W-1:0] eag_dp_t;

    eag_state_e state_q;
    logic [3:0] iter_q;
    eag_dp_t cx_q;
    eag_dp_t cy_q;
    logic [EAG_ANG_W-1:0] cz_q;
    eag_dp_t gx_q;
    eag_dp_t gy_q;
    eag_dp_t gz_q;
    logic fusion_q;
    logic [EAG_SAMPLE_W-1:0] err_max_q;
    logic [EAG_ANG_W-1:0] roll_acc_q;
    logic [EAG_ANG_W-1:0] pitch_acc_q;
    eag_dp_t mag_q;
    logic take;
    eag_dp_t ax;
    eag_dp_t ay;
    eag_dp_t az;
    eag_dp_t err_full;
    logic [EAG_SAMPLE_W-1:0] err_sat;
    logic over_limit;
    logic signed [EAG_ANG_W-1:0] roll_s;
    logic signed [EAG_ANG_W-1:0] pitch_s;

    // Remove the CORDIC gain from a magnitude
    function automatic eag_dp_t eag_comp(input eag_dp_t v);
        logic signed [EAG_DP_W+16:0] p;
        p = v * EAG_KINV;
        eag_comp = p[EAG_DP_W+EAG_KINV_SHIFT-1:EAG_KINV_SHIFT];
    endfunction : eag_comp

    // Widen a sample and optionally negate it
    function automatic eag_dp_t eag_axis(
        input logic signed [EAG_SAMPLE_W-1:0] s,
        input logic neg
    );
        eag_dp_t w;
        w = eag_dp_t'(s);
        eag_axis = neg ? -w : w;
    endfunction : eag_axis

    assign in_ready = (state_q == EAG_IDLE);
    assign take = in_valid && in_ready;

    // Axis permutation and sign per frame selection
    always_comb
    begin
        case (frame_axis_sel)
            EAG_FRAME_YZX:
            begin
                ax = eag_axis(in_gy, frame_negate[0]);
                ay = eag_axis(in_gz, frame_negate[1]);
                az = eag_axis(in_gx, frame_negate[2]);
            end
            EAG_FRAME_ZXY:
            begin
                ax = eag_axis(in_gz, frame_negate[0]);
                ay = eag_axis(in_gx, frame_negate[1]);
                az = eag_axis(in_gy, frame_negate[2]);
            end
            default:
            begin
                ax = eag_axis(in_gx, frame_negate[0]);
                ay = eag_axis(in_gy, frame_negate[1]);
                az = eag_axis(in_gz, frame_negate[2]);
            end
        endcase
    end

    // Sequencer
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= EAG_IDLE;
            iter_q <= 4'h0;
        end
        else
        begin
            case (state_q)
                EAG_IDLE:
                begin
                    iter_q <= 4'h0;
                    if (take)
                    begin
                        state_q <= EAG_PASS1;
                    end
                end
                EAG_PASS1:
                begin
                    iter_q <= iter_q + 4'h1;
                    if (iter_q == EAG_ITER_LAST)
                    begin
                        state_q <= EAG_COMP1;
                    end
                end
                EAG_COMP1:
                begin
                    iter_q <= 4'h0;
                    state_q <= EAG_PASS2;
                end
                EAG_PASS2:
                begin
                    iter_q <= iter_q + 4'h1;
                    if (iter_q == EAG_ITER_LAST)
                    begin
                        state_q <= EAG_COMP2;
                    end
                end
                EAG_COMP2:
                begin
                    state_q <= EAG_FINISH;
                end
                EAG_FINISH:
                begin
                    state_q <= EAG_IDLE;
                end
                default:
                begin
                    state_q <= EAG_IDLE;
                end
            endcase
        end
    end

    // Sample capture with configuration held for the whole computation
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            gx_q <= '0;
            gy_q <= '0;
            gz_q <= '0;
            fusion_q <= 1'b0;
            err_max_q <= EAG_ERR_RST;
        end
        else if (take)
        begin
            gx_q <= ax;
            gy_q <= ay;
            gz_q <= az;
            fusion_q <= fusion_active;
            err_max_q <= grav_err_max;
        end
    end

    // Shared vectoring CORDIC: pass 1 on (z, y), pass 2 on (|yz|, -x)
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cx_q <= '0;
            cy_q <= '0;
            cz_q <= EAG_ANG_ZERO;
            roll_acc_q <= EAG_ANG_ZERO;
            pitch_acc_q <= EAG_ANG_ZERO;
            mag_q <= '0;
        end
        else
        begin
            case (state_q)
                EAG_IDLE:
                begin
                    if (take && az < 0)
                    begin
                        // Fold the left half plane so roll spans 180
                        cx_q <= -az;
                        cy_q <= -ay;
                        cz_q <= EAG_ANG_180;
                    end
                    else if (take)
                    begin
                        cx_q <= az;
                        cy_q <= ay;
                        cz_q <= EAG_ANG_ZERO;
                    end
                end
                EAG_PASS1, EAG_PASS2:
                begin
                    if (cy_q >= 0)
                    begin
                        cx_q <= cx_q + (cy_q >>> iter_q);
                        cy_q <= cy_q - (cx_q >>> iter_q);
                        cz_q <= cz_q + eag_atan(iter_q);
                    end
                    else
                    begin
                        cx_q <= cx_q - (cy_q >>> iter_q);
                        cy_q <= cy_q + (cx_q >>> iter_q);
                        cz_q <= cz_q - eag_atan(iter_q);
                    end
                end
                EAG_COMP1:
                begin
                    // Nonnegative x keeps pitch within 90 degrees
                    roll_acc_q <= cz_q;
                    cx_q <= eag_comp(cx_q);
                    cy_q <= -gx_q;
                    cz_q <= EAG_ANG_ZERO;
                end
                EAG_COMP2:
                begin
                    pitch_acc_q <= cz_q;
                    mag_q <= eag_comp(cx_q);
                end
                default:
                begin
                    cx_q <= cx_q;
                end
            endcase
        end
    end

    // Gravity error against one g, saturated to the output width
    assign err_full = (mag_q > eag_dp_t'(EAG_ONE_G)) ?
        mag_q - eag_dp_t'(EAG_ONE_G) : eag_dp_t'(EAG_ONE_G) - mag_q;
    assign err_sat = (err_full[EAG_DP_W-1:EAG_SAMPLE_W] != '0) ?
        {EAG_SAMPLE_W{1'b1}} : err_full[EAG_SAMPLE_W-1:0];
    assign over_limit = (err_sat > err_max_q) && !fusion_q;

    // CORDIC leaves a few LSB of residue; zero x, or zero y with nonzero z, is exact
    always_comb
    begin
        pitch_s = pitch_acc_q;
        if (gx_q == 0)
        begin
            pitch_s = EAG_ANG_ZERO;
        end
        else if (pitch_s > EAG_ANG_90)
        begin
            pitch_s = EAG_ANG_90;
        end
        else if (pitch_s < -EAG_ANG_90)
        begin
            pitch_s = -EAG_ANG_90;
        end
    end

    always_comb
    begin
        roll_s = roll_acc_q;
        if (gy_q == 0 && gz_q > 0)
        begin
            roll_s = EAG_ANG_ZERO;
        end
        else if (gy_q == 0 && gz_q < 0)
        begin
            roll_s = EAG_ANG_180;
        end
    end

    // Results; no yaw output exists since gravity cannot resolve it
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            out_valid <= 1'b0;
            pitch_out <= EAG_ANG_ZERO;
            roll_out <= EAG_ANG_ZERO;
            rollover_out <= 1'b0;
            roll_lock_out <= 1'b0;
            unit_pitch_lock_out <= 1'b0;
            grav_err_out <= EAG_ERR_RST;
            angle_quality_indicator <= EAG_AQI_OK;
        end
        else
        begin
            out_valid <= (state_q == EAG_FINISH);
            if (state_q == EAG_FINISH)
            begin
                // Zero x gives exact zero pitch; zero y with nonzero z gives exact roll
                pitch_out <= pitch_s;
                roll_out <= roll_s;
                rollover_out <= (roll_s > EAG_ANG_90)
                    || (roll_s < -EAG_ANG_90);
                roll_lock_out <= (gy_q == 0) && (gz_q == 0);
                unit_pitch_lock_out <= (gx_q == 0) && (gz_q == 0);
                grav_err_out <= err_sat;
                angle_quality_indicator <= over_limit ?
                    EAG_AQI_ERROR : EAG_AQI_OK;
            end
        end
    end

endmodule : eag_core

// [eag_pkg.sv]
// Constants for the static gravity angle and gravity error block.
// Assumes samples are signed fixed point in units of standard gravity.
package eag_pkg;

    // Sample format: signed 16 bit, one g equals 8192 counts
    localparam int EAG_SAMPLE_W = 16;
    localparam logic signed [EAG_SAMPLE_W-1:0] EAG_ONE_G = 16'sh2000;

    // Internal datapath width, headroom for the CORDIC gain
    localparam int EAG_DP_W = 22;

    // Angles: 16 bit binary angle, 16'h4000 is 90 degrees
    localparam int EAG_ANG_W = 16;
    localparam logic signed [EAG_ANG_W-1:0] EAG_ANG_ZERO = 16'sh0000;
    localparam logic signed [EAG_ANG_W-1:0] EAG_ANG_90 = 16'sh4000;
    localparam logic signed [EAG_ANG_W-1:0] EAG_ANG_180 = 16'sh8000;

    // CORDIC iteration count and reciprocal gain, 0.60725 in Q15
    localparam int EAG_ITER = 14;
    localparam logic [3:0] EAG_ITER_LAST = 4'hd;
    localparam logic signed [16:0] EAG_KINV = 17'sh04dba;
    localparam int EAG_KINV_SHIFT = 15;

    // Frame reorientation selections
    localparam logic [1:0] EAG_FRAME_XYZ = 2'h0;
    localparam logic [1:0] EAG_FRAME_YZX = 2'h1;
    localparam logic [1:0] EAG_FRAME_ZXY = 2'h2;

    // Angle quality indicator codes
    localparam logic [1:0] EAG_AQI_OK = 2'h0;
    localparam logic [1:0] EAG_AQI_ERROR = 2'h3;

    // Output reset values
    localparam logic [EAG_SAMPLE_W-1:0] EAG_ERR_RST = 16'h0000;

    typedef enum {
        EAG_IDLE,
        EAG_PASS1,
        EAG_COMP1,
        EAG_PASS2,
        EAG_COMP2,
        EAG_FINISH
    } eag_state_e;

    // Arctangent of 2^-i as binary angle
    function automatic logic [EAG_ANG_W-1:0] eag_atan(input logic [3:0] i);
        case (i)
            4'h0: eag_atan = 16'h2000;
            4'h1: eag_atan = 16'h12e4;
            4'h2: eag_atan = 16'h09fb;
            4'h3: eag_atan = 16'h0511;
            4'h4: eag_atan = 16'h028b;
            4'h5: eag_atan = 16'h0146;
            4'h6: eag_atan = 16'h00a3;
            4'h7: eag_atan = 16'h0051;
            4'h8: eag_atan = 16'h0029;
            4'h9: eag_atan = 16'h0014;
            4'ha: eag_atan = 16'h000a;
            4'hb: eag_atan = 16'h0005;
            4'hc: eag_atan = 16'h0003;
            4'hd: eag_atan = 16'h0001;
            default: eag_atan = 16'h0000;
        endcase
    endfunction : eag_atan

endpackage : eag_pkg

// [eag_core_assertions.sv]
// Port checker for eag_core: answer timing, flags and quality.
// Assumes one clock, rst synchronous and active high.
`timescale 1ns/1ns

module eag_core_assertions
    import eag_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic in_ready,
    input wire logic signed [15:0] in_gx,
    input wire logic signed [15:0] in_gy,
    input wire logic signed [15:0] in_gz,
    input wire logic [1:0] frame_axis_sel,
    input wire logic [2:0] frame_negate,
    input wire logic fusion_active,
    input wire logic [15:0] grav_err_max,
    input wire logic out_valid,
    input wire logic signed [15:0] pitch_out,
    input wire logic signed [15:0] roll_out,
    input wire logic rollover_out,
    input wire logic roll_lock_out,
    input wire logic unit_pitch_lock_out,
    input wire logic [15:0] grav_err_out,
    input wire logic [1:0] angle_quality_indicator
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_take;
        in_valid && in_ready;
    endsequence
    sequence s_done;
        ##32 out_valid;
    endsequence

    property p_lock;
        logic ly, lx;
        (in_valid && in_ready && frame_axis_sel == EAG_FRAME_XYZ,
         ly = (in_gy == 0 && in_gz == 0), lx = (in_gx == 0 && in_gz == 0))
        |-> s_done ##0 (roll_lock_out == ly && unit_pitch_lock_out == lx);
    endproperty
    property p_qual;
        logic [15:0] lm;
        logic lf;
        (in_valid && in_ready, lm = grav_err_max, lf = fusion_active)
        |-> s_done ##0 angle_quality_indicator ==
            ((!lf && grav_err_out > lm) ? EAG_AQI_ERROR : EAG_AQI_OK);
    endproperty

    a_answer_time: assert property (s_take |-> s_done)
        else $error("result not on time");
    a_busy_hold: assert property (s_take |=> !in_ready [*8])
        else $error("ready while busy");
    a_pulse_once: assert property (out_valid |=> !out_valid)
        else $error("valid longer than one cycle");
    a_pitch_range: assert property (out_valid |->
        pitch_out <= EAG_ANG_90 && pitch_out >= -EAG_ANG_90)
        else $error("pitch out of range");
    a_rollover_flag: assert property (out_valid |-> rollover_out ==
        (roll_out > EAG_ANG_90 || roll_out < -EAG_ANG_90))
        else $error("rollover flag wrong");
    a_level_zero: assert property ((in_valid && in_ready && in_gx == 0 &&
        in_gy == 0 && in_gz == EAG_ONE_G && frame_axis_sel == 2'h0 &&
        frame_negate == 3'h0) |-> s_done ##0 (pitch_out == 0 &&
        roll_out == 0))
        else $error("level angles not zero");
    a_lock_flags: assert property (p_lock)
        else $error("gimbal lock flag wrong");
    a_quality_code: assert property (p_qual)
        else $error("quality code wrong");
endmodule : eag_core_assertions

bind eag_core eag_core_assertions u_chk (.clk(clk), .rst(rst),
    .in_valid(in_valid), .in_ready(in_ready), .in_gx(in_gx), .in_gy(in_gy),
    .in_gz(in_gz), .frame_axis_sel(frame_axis_sel),
    .frame_negate(frame_negate), .fusion_active(fusion_active),
    .grav_err_max(grav_err_max), .out_valid(out_valid),
    .pitch_out(pitch_out), .roll_out(roll_out), .rollover_out(rollover_out),
    .roll_lock_out(roll_lock_out), .unit_pitch_lock_out(unit_pitch_lock_out),
    .grav_err_out(grav_err_out),
    .angle_quality_indicator(angle_quality_indicator));

// [eag_src_model.sv]
// Sample source model: offers one gravity sample per request.
// Assumes req is a one-cycle pulse set at a falling edge.
`timescale 1ns/1ns

module eag_src_model
(
    input wire logic clk,
    input wire logic req,
    input wire logic [15:0] x,
    input wire logic [15:0] y,
    input wire logic [15:0] z,
    input wire logic in_ready,
    output logic in_valid,
    output logic [15:0] in_gx,
    output logic [15:0] in_gy,
    output logic [15:0] in_gz
);
    logic taken_q;

    initial
    begin
        in_valid = 1'b0;
        in_gx = 16'h0000;
        in_gy = 16'h0000;
        in_gz = 16'h0000;
    end

    always @(posedge clk)
        taken_q <= in_valid && in_ready;

    // Held until taken, then lines flip so stale data never matches
    always @(negedge clk)
    begin
        if (taken_q)
        begin
            in_valid <= 1'b0;
            in_gx <= ~in_gx;
            in_gy <= ~in_gy;
            in_gz <= ~in_gz;
        end
        if (req)
        begin
            in_valid <= 1'b1;
            in_gx <= x;
            in_gy <= y;
            in_gz <= z;
        end
    end
endmodule : eag_src_model

// [euler_angle_gravity_check_tb_top.sv]
// Self-checking bench for eag_core with a sample source model.
// Assumes 8192 counts per g and binary angle outputs.
`timescale 1ns/1ns

module euler_angle_gravity_check_tb_top
    import eag_pkg::*;
;
    logic clk, rst, req, fa, in_valid, in_ready, out_valid;
    logic [15:0] sx, sy, sz, gx, gy, gz, mx, pitch, roll, err;
    logic [1:0] sel, aqi;
    logic [2:0] ng;
    logic rovr, rlock, plock;
    int fails, cmp_count;

    eag_src_model src (.clk(clk), .req(req), .x(sx), .y(sy), .z(sz),
        .in_ready(in_ready), .in_valid(in_valid), .in_gx(gx), .in_gy(gy),
        .in_gz(gz));
    eag_core dut (.clk(clk), .rst(rst), .in_valid(in_valid),
        .in_ready(in_ready), .in_gx(gx), .in_gy(gy), .in_gz(gz),
        .frame_axis_sel(sel), .frame_negate(ng), .fusion_active(fa),
        .grav_err_max(mx), .out_valid(out_valid), .pitch_out(pitch),
        .roll_out(roll), .rollover_out(rovr), .roll_lock_out(rlock),
        .unit_pitch_lock_out(plock), .grav_err_out(err),
        .angle_quality_indicator(aqi));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    task cmp_ang(input logic [15:0] got, input int exp, input int t);
        logic [15:0] d;
        d = got - 16'(exp);
        cmp_count++;
        if ((^got === 1'bx) || $signed(d) > t || $signed(d) < -t)
        begin
            fails++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_ang

    task cmp_v(input logic [1:0] got, input logic [1:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %0t flag %h exp %h", $time, got, exp);
        end
    endtask : cmp_v

    task run(input int x, y, z, s, n, f, m);
        int k;
        @(negedge clk);
        req <= 1'b1;
        sx <= 16'(x);
        sy <= 16'(y);
        sz <= 16'(z);
        sel <= 2'(s);
        ng <= 3'(n);
        fa <= f[0];
        mx <= 16'(m);
        @(negedge clk);
        req <= 1'b0;
        k = 0;
        while (out_valid !== 1'b1 && k < 100)
        begin
            @(negedge clk);
            k++;
        end
        if (k == 100)
            cmp_v(2'h1, 2'h0);
    endtask : run

    task t_angles;
        run(0, 0, 16'h2000, 0, 0, 0, 16'h0100);
        cmp_ang(pitch, 0, 0);
        cmp_ang(roll, 0, 0);
        cmp_ang(err, 0, 16);
        run(0, 16'h16a1, 16'he95f, 0, 0, 0, 16'hffff);
        cmp_ang(roll, 16'h6000, 8);
        cmp_v({1'b0, rovr}, 2'h1);
        run(0, 16'he95f, 16'h16a1, 0, 0, 0, 16'hffff);
        cmp_ang(roll, 16'he000, 8);
        cmp_v({1'b0, rovr}, 2'h0);
        run(16'he95f, 0, 16'h16a1, 0, 0, 0, 16'hffff);
        cmp_ang(pitch, 16'h2000, 8);
        cmp_ang(roll, 0, 8);
    endtask : t_angles

    task t_lock;
        run(16'he000, 0, 0, 0, 0, 0, 16'hffff);
        cmp_ang(pitch, 16'h4000, 8);
        cmp_v({rlock, plock}, 2'h2);
        run(0, 16'h2000, 0, 0, 0, 0, 16'hffff);
        cmp_ang(roll, 16'h4000, 8);
        cmp_v({rlock, plock}, 2'h1);
    endtask : t_lock

    task t_error;
        run(0, 0, 16'h4000, 0, 0, 0, 16'h1000);
        cmp_ang(err, 16'h2000, 16);
        cmp_v(aqi, EAG_AQI_ERROR);
        run(0, 0, 16'h4000, 0, 0, 1, 16'h1000);
        cmp_v(aqi, EAG_AQI_OK);
        run(0, 0, 16'h4000, 0, 0, 0, 16'h3000);
        cmp_v(aqi, EAG_AQI_OK);
        run(0, 0, 16'h1000, 0, 0, 0, 16'h0800);
        cmp_ang(err, 16'h1000, 16);
        cmp_v(aqi, EAG_AQI_ERROR);
    endtask : t_error

    task t_frame;
        run(16'h2000, 0, 0, 1, 0, 0, 16'hffff);
        cmp_ang(roll, 0, 8);
        run(16'h2000, 0, 0, 1, 3'h4, 0, 16'hffff);
        cmp_ang(roll, 16'h8000, 8);
        cmp_v({1'b0, rovr}, 2'h1);
        run(0, 16'h2000, 0, 2, 0, 0, 16'hffff);
        cmp_ang(pitch, 0, 8);
    endtask : t_frame

    initial
    begin
        {rst, req, fa, sel, ng} = 8'h80;
        {sx, sy, sz, mx} = 64'h0;
        fails = 0;
        cmp_count = 0;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        t_angles;
        t_lock;
        t_error;
        t_frame;
        wrap_up;
    end

    initial
    begin
        #20000;
        fails++;
        wrap_up;
    end
endmodule : euler_angle_gravity_check_tb_top
